// >>> ipmc_consts.svh
// Register offsets, field positions and reset values of the power mux control
`ifndef IPMC_CONSTS_SVH
`define IPMC_CONSTS_SVH
`define IPMC_OFF_DRIVE    32'h0000_0000
`define IPMC_OFF_MUXCTL   32'h0000_0004
`define IPMC_OFF_STATUS   32'h0000_0008
`define IPMC_OFF_ADC      32'h0000_000C
`define IPMC_DP_LSB       0
`define IPMC_DM_LSB       4
`define IPMC_EN1_BIT      0
`define IPMC_EN2_BIT      1
`define IPMC_DISALL_BIT   2
`define IPMC_HIZ_BIT      3
`define IPMC_DIS_BIT      4
`define IPMC_DM_RD_LSB    16
`define IPMC_MUXCTL_RST   5'h03
`define IPMC_PROBE_CYC    4'h8
`endif

// >>> ipmc_pkg.sv
// Types shared by the power mux control block
package ipmc_pkg;
    // D+ drive codes
    typedef enum logic [2:0] {
        IPMC_DP_HIZ   = 3'h0,
        IPMC_DP_0V0   = 3'h1,
        IPMC_DP_0V6   = 3'h2,
        IPMC_DP_1V2   = 3'h3,
        IPMC_DP_2V0   = 3'h4,
        IPMC_DP_2V7   = 3'h5,
        IPMC_DP_3V3   = 3'h6,
        IPMC_DP_SHORT = 3'h7
    } ipmc_dp_t;
    // D- drive codes; 0V and short are not offered on D-
    typedef enum logic [2:0] {
        IPMC_DM_HIZ = 3'h0,
        IPMC_DM_0V6 = 3'h2,
        IPMC_DM_1V2 = 3'h3,
        IPMC_DM_2V0 = 3'h4,
        IPMC_DM_2V7 = 3'h5,
        IPMC_DM_3V3 = 3'h6
    } ipmc_dm_t;
    typedef enum logic [2:0] {
        IPMC_PROBE = 3'b001,
        IPMC_LATCH = 3'b010,
        IPMC_RUN   = 3'b100
    } ipmc_state_t;
endpackage

// >>> ipmc_top.sv
// Dual input power mux gate control and D+/D- fault probe drive
`include "ipmc_consts.svh"
module ipmc_top (
    // Clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Analog status pins
    input  wire logic        input1_gate_grounded,
    input  wire logic        input2_gate_grounded,
    input  wire logic        source1_sense_ok,
    input  wire logic        source2_sense_ok,
    input  wire logic        bus_present,
    input  wire logic        detect_busy,
    input  wire logic [15:0] dp_adc,
    input  wire logic [15:0] dm_adc,
    // Gate drivers and D+/D- drive
    output logic             input1_gate_drive,
    output logic             input2_gate_drive,
    output ipmc_pkg::ipmc_dp_t dp_drive_setting,
    output ipmc_pkg::ipmc_dm_t dm_drive_setting,
    output logic             dpdm_drive_source1
);
    import ipmc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [5:0] sync1, sync2, next_sync1, next_sync2;
    logic [31:0] adc1, adc2, next_adc1, next_adc2;
    logic [31:0] adc3, adc_hold, next_adc3, next_adc_hold;
    logic g1_gnd, g2_gnd, s1_ok, s2_ok, vbus_p, det_busy;
    assign {g1_gnd, g2_gnd, s1_ok, s2_ok, vbus_p, det_busy} = sync2;

    always_comb begin
        next_sync1 = {input1_gate_grounded, input2_gate_grounded,
                      source1_sense_ok, source2_sense_ok,
                      bus_present, detect_busy};
        next_sync2 = sync1;
        next_adc1  = {dm_adc, dp_adc};
        next_adc2  = adc1;
        next_adc3  = adc2;
        // A reading may change under the flops; only two equal samples count
        next_adc_hold = (adc2 == adc3) ? adc3 : adc_hold;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
            adc1  <= 32'h0000_0000;
            adc2  <= 32'h0000_0000;
            adc3  <= 32'h0000_0000;
            adc_hold <= 32'h0000_0000;
        end else if (clk_en) begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            adc1  <= next_adc1;
            adc2  <= next_adc2;
            adc3  <= next_adc3;
            adc_hold <= next_adc_hold;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-on FET probe
    ipmc_state_t state, next_state;
    logic [3:0]  probe_cnt, next_probe_cnt;
    logic        fet1, fet2, next_fet1, next_fet2;

    always_comb begin
        next_state     = state;
        next_probe_cnt = probe_cnt;
        next_fet1      = fet1;
        next_fet2      = fet2;
        case (state)
            IPMC_PROBE: begin
                // Let the pin synchronisers settle before sampling
                next_probe_cnt = probe_cnt + 4'h1;
                if (probe_cnt == `IPMC_PROBE_CYC - 4'h1) begin
                    next_state = IPMC_LATCH;
                end
            end
            IPMC_LATCH: begin
                next_fet1  = !g1_gnd;
                next_fet2  = !g2_gnd;
                next_state = IPMC_RUN;
            end
            IPMC_RUN: begin
                next_state = IPMC_RUN;
            end
            default: begin
                next_state = IPMC_PROBE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state     <= IPMC_PROBE;
            probe_cnt <= 4'h0;
            fet1      <= 1'b0;
            fet2      <= 1'b0;
        end else if (clk_en) begin
            state     <= next_state;
            probe_cnt <= next_probe_cnt;
            fet1      <= next_fet1;
            fet2      <= next_fet2;
        end
    end

    logic probed;
    logic no_fets;
    assign probed  = (state == IPMC_RUN);
    assign no_fets = probed && !fet1 && !fet2;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave and registers
    logic        ap_wr, next_ap_wr;
    logic [31:0] ap_addr, next_ap_addr;
    logic [2:0]  dp_set, next_dp_set;
    logic [2:0]  dm_set, next_dm_set;
    logic [4:0]  muxctl, next_muxctl;
    logic [31:0] next_hrdata;
    logic        en1, en2, dis_all, hiz, dis;

    // Word offsets decode on the low byte; the bus select does the rest
    function automatic logic ipmc_hit(input logic [31:0] a,
                                      input logic [31:0] off);
        return a[7:0] == off[7:0];
    endfunction

    function automatic logic [2:0] ipmc_dm_legal(input logic [2:0] code);
        // D- has no 0V or short; unsupported codes fall back to hiz
        if (code == 3'h1 || code == 3'h7) begin
            return IPMC_DM_HIZ;
        end
        return code;
    endfunction

    function automatic logic [31:0] ipmc_read(input logic [31:0] a);
        if (ipmc_hit(a, `IPMC_OFF_DRIVE)) begin
            return {25'h0, dm_set, 1'b0, dp_set};
        end else if (ipmc_hit(a, `IPMC_OFF_MUXCTL)) begin
            return {27'h0, muxctl};
        end else if (ipmc_hit(a, `IPMC_OFF_STATUS)) begin
            return {29'h0, probed, fet2, fet1};
        end else if (ipmc_hit(a, `IPMC_OFF_ADC)) begin
            return adc_hold;
        end
        return 32'h0000_0000;
    endfunction

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign {dis, hiz, dis_all, en2, en1} = muxctl;

    always_comb begin
        next_ap_wr   = 1'b0;
        next_ap_addr = ap_addr;
        next_dp_set  = dp_set;
        next_dm_set  = dm_set;
        next_muxctl  = muxctl;
        next_hrdata  = hrdata;
        if (hready && hsel && htrans[1]) begin
            next_ap_wr   = hwrite;
            next_ap_addr = haddr;
            if (!hwrite) begin
                next_hrdata = ipmc_read(haddr);
            end
        end
        if (ap_wr && ipmc_hit(ap_addr, `IPMC_OFF_DRIVE) && !det_busy) begin
            next_dp_set = hwdata[`IPMC_DP_LSB +: 3];
            next_dm_set = ipmc_dm_legal(hwdata[`IPMC_DM_LSB +: 3]);
        end else if (ap_wr && ipmc_hit(ap_addr, `IPMC_OFF_MUXCTL)) begin
            next_muxctl = hwdata[4:0];
        end
        // Probe results override host writes for missing pairs
        if (probed && !fet1) begin
            next_muxctl[`IPMC_EN1_BIT] = 1'b0;
        end
        if (probed && !fet2) begin
            next_muxctl[`IPMC_EN2_BIT] = 1'b0;
        end
        if (no_fets) begin
            next_muxctl[`IPMC_DIS_BIT] = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr   <= 1'b0;
            ap_addr <= 32'h0000_0000;
            dp_set  <= IPMC_DP_HIZ;
            dm_set  <= IPMC_DM_HIZ;
            muxctl  <= `IPMC_MUXCTL_RST;
            hrdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            ap_wr   <= next_ap_wr;
            ap_addr <= next_ap_addr;
            dp_set  <= next_dp_set;
            dm_set  <= next_dm_set;
            muxctl  <= next_muxctl;
            hrdata  <= next_hrdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gate drivers and probe drive outputs
    logic next_g1, next_g2;
    logic common_ok;

    always_comb begin
        common_ok = probed && !dis_all && !dis && !hiz && !vbus_p;
        // Re-evaluated every cycle, so any failing condition drops it
        next_g1 = common_ok && fet1 && en1 && s1_ok;
        next_g2 = common_ok && fet2 && en2 && s2_ok;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            input1_gate_drive <= 1'b0;
            input2_gate_drive <= 1'b0;
        end else if (clk_en) begin
            input1_gate_drive <= next_g1;
            input2_gate_drive <= next_g2;
        end
    end

    // Drive reaches only the source 1 connector
    assign dp_drive_setting   = ipmc_dp_t'(dp_set);
    assign dm_drive_setting   = ipmc_dm_t'(dm_set);
    assign dpdm_drive_source1 = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    // The drivers are registered, so their conditions are one cycle back
    a_gate1_cond: assert property (@(posedge hclk) disable iff (!hresetn)
        input1_gate_drive |-> $past(fet1) && $past(en1) && $past(probed))
        else $error("Gate 1 on without its conditions");
    a_gate2_cond: assert property (@(posedge hclk) disable iff (!hresetn)
        input2_gate_drive |-> $past(fet2) && $past(en2) && $past(probed))
        else $error("Gate 2 on without its conditions");
    a_gate1_on: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && probed && fet1 && en1 && s1_ok && !vbus_p
            && !dis_all && !dis && !hiz |=> input1_gate_drive)
        else $error("Gate 1 off with all conditions met");
    a_gate2_on: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && probed && fet2 && en2 && s2_ok && !vbus_p
            && !dis_all && !dis && !hiz |=> input2_gate_drive)
        else $error("Gate 2 off with all conditions met");
    a_sense_drop: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && !s1_ok |=> !input1_gate_drive)
        else $error("Gate 1 stayed on with source sense bad");
    a_mode_drop: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && (dis_all || dis || hiz)
            |=> !input1_gate_drive && !input2_gate_drive)
        else $error("Gate stayed on while disabled");
    a_fet1_lock: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && probed && !fet1 |=> !en1)
        else $error("Enable 1 not locked");
    a_gate_drop: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && vbus_p |=> !input1_gate_drive && !input2_gate_drive)
        else $error("Gate stayed on with bus present");
    a_nofet_lock: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && no_fets |=> dis && !en1 && !en2)
        else $error("No-FET case not locked");
    a_fet2_lock: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && probed && !fet2 |=> !en2)
        else $error("Enable 2 not locked");
    a_drive_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && det_busy |=> $stable(dp_set) && $stable(dm_set))
        else $error("Drive write taken during detection");
    a_dm_legal: assert property (@(posedge hclk) disable iff (!hresetn)
        dm_set != 3'h1 && dm_set != 3'h7)
        else $error("Illegal D- drive code");
    a_probe_time: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(probed) |-> $past(state) == IPMC_LATCH)
        else $error("Probe result without latch");
    a_fet_static: assert property (@(posedge hclk) disable iff (!hresetn)
        probed |=> $stable(fet1) && $stable(fet2))
        else $error("Probe result changed after power-on");
endmodule

// >>> ipmc_board.sv
// Board model: external FET pairs, source comparators and D+/D- sense
module ipmc_board (
    // Board build and source state
    input  wire logic        fit1,
    input  wire logic        fit2,
    input  wire logic        src1_on,
    input  wire logic        src2_on,
    input  wire logic        vbus_on,
    // D+/D- drive from the block
    input  wire logic [2:0]  dp_code,
    input  wire logic [2:0]  dm_code,
    // Pins seen by the block
    output logic             gnd1,
    output logic             gnd2,
    output logic             ok1,
    output logic             ok2,
    output logic             bus,
    output logic [15:0]      dp_adc,
    output logic [15:0]      dm_adc
);
    timeunit 1ns;
    timeprecision 1ps;
    // An absent pair has its gate pin grounded and its sense tied to bus
    assign gnd1 = !fit1;
    assign gnd2 = !fit2;
    assign ok1 = fit1 ? src1_on : vbus_on;
    assign ok2 = fit2 ? src2_on : vbus_on;
    assign bus = vbus_on;
    // Pin voltage follows the applied drive code, tagged per line
    assign dp_adc = {4'h1, 9'h000, dp_code};
    assign dm_adc = {4'h2, 9'h000, dm_code};
endmodule

// >>> test_ipmc_top.sv
// Self-checking bench for the power mux control block
`include "ipmc_consts.svh"
module test_ipmc_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hwrite, f1, f2, s1, s2, vb, busy;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata;
    wire logic [31:0] hrdata;
    wire logic        rdy, resp, g1, g2, src1, gg1, gg2, ok1, ok2, bp;
    wire logic [2:0]  dp, dm;
    wire logic [15:0] dpa, dma;
    int          err_total, checks_done;

    ipmc_top uut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata),
        .hreadyout(rdy), .hresp(resp), .input1_gate_grounded(gg1),
        .input2_gate_grounded(gg2), .source1_sense_ok(ok1),
        .source2_sense_ok(ok2), .bus_present(bp), .detect_busy(busy),
        .dp_adc(dpa), .dm_adc(dma), .input1_gate_drive(g1),
        .input2_gate_drive(g2), .dp_drive_setting(dp),
        .dm_drive_setting(dm), .dpdm_drive_source1(src1));
    ipmc_board board (.fit1(f1), .fit2(f2), .src1_on(s1), .src2_on(s2),
        .vbus_on(vb), .dp_code(dp), .dm_code(dm), .gnd1(gg1), .gnd2(gg2),
        .ok1(ok1), .ok2(ok2), .bus(bp), .dp_adc(dpa), .dm_adc(dma));

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One single transfer; the wait ends only when the slave is ready
    task automatic bus(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
        @(posedge hclk);
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (rdy !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (rdy !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [31:0] a, exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        chk(r, exp);
    endtask
    task automatic gates(input logic [1:0] exp);
        repeat (6) @(posedge hclk);
        chk({30'h0, g2, g1}, {30'h0, exp});
    endtask
    task automatic do_reset(input logic a, b);
        @(posedge hclk);
        f1 <= a;
        f2 <= b;
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (14) @(posedge hclk);
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_nofet;
        do_reset(1'b0, 1'b0);
        rd(`IPMC_OFF_STATUS, 32'h0000_0004);
        rd(`IPMC_OFF_MUXCTL, 32'h0000_0010);
        wr(`IPMC_OFF_MUXCTL, 32'h0000_0003);
        rd(`IPMC_OFF_MUXCTL, 32'h0000_0010);
        gates(2'b00);
    endtask
    task automatic t_one;
        do_reset(1'b1, 1'b0);
        rd(`IPMC_OFF_STATUS, 32'h0000_0005);
        rd(`IPMC_OFF_MUXCTL, 32'h0000_0001);
        gates(2'b01);
    endtask
    task automatic t_both;
        do_reset(1'b1, 1'b1);
        rd(`IPMC_OFF_STATUS, 32'h0000_0007);
        rd(`IPMC_OFF_MUXCTL, 32'h0000_0003);
        gates(2'b11);
        // Each disable bit alone must drop both drivers
        for (int b = 2; b < 5; b++) begin
            wr(`IPMC_OFF_MUXCTL, 32'h0000_0003 | (32'h1 << b));
            gates(2'b00);
            wr(`IPMC_OFF_MUXCTL, 32'h0000_0003);
        end
        wr(`IPMC_OFF_MUXCTL, 32'h0000_0001);
        gates(2'b01);
        wr(`IPMC_OFF_MUXCTL, 32'h0000_0003);
        vb <= 1'b1;
        gates(2'b00);
        vb <= 1'b0;
        s1 <= 1'b0;
        gates(2'b10);
    endtask
    task automatic t_dpdm;
        logic [2:0] e;
        for (int i = 0; i < 8; i++) begin
            e = (i == 1 || i == 7) ? 3'h0 : i[2:0];
            wr(`IPMC_OFF_DRIVE, {25'h0, i[2:0], 1'b0, i[2:0]});
            rd(`IPMC_OFF_DRIVE, {25'h0, e, 1'b0, i[2:0]});
            chk({26'h0, dm, dp}, {26'h0, e, i[2:0]});
            chk({31'h0, src1}, 32'h0000_0001);
            chk({31'h0, resp}, 32'h0000_0000);
            repeat (4) @(posedge hclk);
            rd(`IPMC_OFF_ADC, {4'h2, 9'h0, e, 4'h1, 9'h0, i[2:0]});
        end
        busy <= 1'b1;
        repeat (4) @(posedge hclk);
        wr(`IPMC_OFF_DRIVE, 32'h0000_0036);
        rd(`IPMC_OFF_DRIVE, 32'h0000_0007);
        busy <= 1'b0;
        repeat (4) @(posedge hclk);
        wr(`IPMC_OFF_DRIVE, 32'h0000_0036);
        rd(`IPMC_OFF_DRIVE, 32'h0000_0036);
        wr(`IPMC_OFF_STATUS, 32'hFFFF_FFFF);
        rd(`IPMC_OFF_STATUS, 32'h0000_0007);
        rd(32'h0000_0010, 32'h0000_0000);
    endtask

    initial begin
        {hresetn, hwrite, htrans, haddr, hwdata} = '0;
        {f1, f2, vb, busy} = '0;
        {s1, s2} = 2'b11;
        err_total = 0;
        checks_done = 0;
        t_nofet();
        t_one();
        t_both();
        t_dpdm();
        tally_and_finish();
    end
    // Whole run is about 300 cycles; this cuts a hung handshake
    initial begin
        #40000;
        err_total++;
        tally_and_finish();
    end
endmodule
